// ==== logic/ifb_pkg.sv ====
// Constants for the first interrupt flag word and its AXI4-Lite register map.
// Assumes a single 125 MHz clock and an asynchronous active-low reset.
// Summary of operation
// - An implemented flag reads 1 once its source has requested or software has written it to 1, and 0 while neither happened.
// - Bit 13 is converter_done_flag, set when a conversion completes.
// - Bit 12 is serial_tx_flag, set by the serial transmitter request.
// - Bit 11 is serial_rx_flag, set by the serial receiver request.
// - Bit 10 is spi_event_flag, set by the SPI transfer event request.
// - Bit 9 is spi_fault_flag, set by the SPI fault request.
// - Bit 8 is timer3_flag, set by the third timer request.
// - Bit 7 is timer2_flag, set by the second timer request.
// - Bit 6 is compare2_flag, set by output compare channel 2.
// - Bit 5 is capture2_flag, set by input capture channel 2.
// - Bits 15, 14 and 4 have no storage, read 0 and ignore writes.
// - Bit 1 is capture1_flag, set by input capture channel 1.
// - Bit 0 is ext_int0_flag, set when external interrupt 0 sees its edge.
package ifb_pkg;
    localparam int          IFB_WIDTH       = 16;
    localparam logic [15:0] IFB_IMPL_MASK   = 16'h3FEF;
    localparam logic [15:0] IFB_FLAG_RESET  = 16'h0000;
    localparam logic [15:0] IFB_MASK_RESET  = 16'h0000;
    localparam logic [3:0]  IFB_OFS_FLAG    = 4'h0;
    localparam logic [3:0]  IFB_OFS_SET     = 4'h4;
    localparam logic [3:0]  IFB_OFS_MASK    = 4'h8;
    localparam logic [3:0]  IFB_OFS_PEND    = 4'hC;
    localparam int          IFB_BIT_CONV    = 13;
    localparam int          IFB_BIT_STX     = 12;
    localparam int          IFB_BIT_SRX     = 11;
    localparam int          IFB_BIT_SPIE    = 10;
    localparam int          IFB_BIT_SPIF    = 9;
    localparam int          IFB_BIT_TMR3    = 8;
    localparam int          IFB_BIT_TMR2    = 7;
    localparam int          IFB_BIT_CMP2    = 6;
    localparam int          IFB_BIT_CAP2    = 5;
    localparam int          IFB_BIT_TMR1    = 3;
    localparam int          IFB_BIT_CMP1    = 2;
    localparam int          IFB_BIT_CAP1    = 1;
    localparam int          IFB_BIT_EXT0    = 0;
    localparam logic [1:0]  IFB_RESP_OKAY   = 2'h0;
    localparam logic [1:0]  IFB_RESP_SLVERR = 2'h2;
endpackage : ifb_pkg

// ==== logic/ifb_flag_if.sv ====
// Interface carrying the flag word between the bus slave and the flag bank.
// Assumes both ends share one clock.
`timescale 1ns/100ps
interface ifb_flag_if;
    logic        wr_flag;
    logic        wr_set;
    logic [15:0] wdata;
    logic [15:0] flags;
    modport ctrl (output wr_flag, output wr_set, output wdata, input flags);
    modport bank (input wr_flag, input wr_set, input wdata, output flags);
endinterface : ifb_flag_if

// ==== logic/ifb_flag_bank.sv ====
// Sticky flag bank of the first interrupt flag word.
// Assumes one-cycle-or-longer request levels from peripherals, synchronous to clk.
`timescale 1ns/100ps
module ifb_flag_bank
    import ifb_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic [15:0] req,
    ifb_flag_if.bank         fl
);
    typedef struct packed {
        logic [15:0] flag;
    } ifb_bank_t;

    ifb_bank_t s_q;
    ifb_bank_t s_d;

    always_comb begin
        s_d = s_q;
        // Software write, then set wins over clear
        if (fl.wr_flag) begin
            s_d.flag = fl.wdata;
        end
        if (fl.wr_set) begin
            s_d.flag = s_q.flag | fl.wdata;
        end
        s_d.flag = (s_d.flag | req) & IFB_IMPL_MASK;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q.flag <= IFB_FLAG_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign fl.flags = s_q.flag;

    sticky_set_a: assert property (@(posedge clk) disable iff (!arst_n)
        (req[IFB_BIT_CONV] && !fl.wr_flag) |=> fl.flags[IFB_BIT_CONV])
        else $error("converter flag missed its request");
    unimpl_zero_a: assert property (@(posedge clk) disable iff (!arst_n)
        (fl.flags & ~IFB_IMPL_MASK) == 16'h0000)
        else $error("unimplemented flag bit set");
    hold_flag_a: assert property (@(posedge clk) disable iff (!arst_n)
        (!fl.wr_flag && !fl.wr_set && req == 16'h0000) |=> fl.flags == $past(fl.flags))
        else $error("flag changed without cause");
    clear_write_a: assert property (@(posedge clk) disable iff (!arst_n)
        (fl.wr_flag && !fl.wr_set && req == 16'h0000)
        |=> fl.flags == ($past(fl.wdata) & IFB_IMPL_MASK))
        else $error("software write not stored");
endmodule : ifb_flag_bank

// ==== logic/ifb_top.sv ====
// Top of the first interrupt flag word: AXI4-Lite slave, flag bank, mask and irq.
// Assumes an AXI4-Lite master with at most one read and one write in flight.
//
// Decided for this implementation: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/100ps
module ifb_top
    import ifb_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        converter_done_req,
    input  wire logic        serial_tx_req,
    input  wire logic        serial_rx_req,
    input  wire logic        spi_event_req,
    input  wire logic        spi_fault_req,
    input  wire logic        timer3_req,
    input  wire logic        timer2_req,
    input  wire logic        compare2_req,
    input  wire logic        capture2_req,
    input  wire logic        timer1_req,
    input  wire logic        compare1_req,
    input  wire logic        capture1_req,
    input  wire logic        ext_int0_req,
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             irq
);
    typedef struct packed {
        logic        aw_held;
        logic [3:0]  awaddr;
        logic        w_held;
        logic [15:0] wdata;
        logic [1:0]  wstrb;
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic [15:0] mask;
        logic        irq;
    } ifb_top_t;

    ifb_top_t    s_q;
    ifb_top_t    s_d;
    logic [15:0] req;
    logic        wr_flag;
    logic        wr_set;
    logic [15:0] wmerged;

    ifb_flag_if fl ();

    // Map each source request onto its flag position
    always_comb begin
        req               = 16'h0000;
        req[IFB_BIT_CONV] = converter_done_req;
        req[IFB_BIT_STX]  = serial_tx_req;
        req[IFB_BIT_SRX]  = serial_rx_req;
        req[IFB_BIT_SPIE] = spi_event_req;
        req[IFB_BIT_SPIF] = spi_fault_req;
        req[IFB_BIT_TMR3] = timer3_req;
        req[IFB_BIT_TMR2] = timer2_req;
        req[IFB_BIT_CMP2] = compare2_req;
        req[IFB_BIT_CAP2] = capture2_req;
        req[IFB_BIT_TMR1] = timer1_req;
        req[IFB_BIT_CMP1] = compare1_req;
        req[IFB_BIT_CAP1] = capture1_req;
        req[IFB_BIT_EXT0] = ext_int0_req;
    end

    // Apply byte strobes over the old word passed in (current contents, or zero for the set register)
    function automatic logic [15:0] ifb_merge(input logic [15:0] old, input logic [15:0] nw,
                                              input logic [1:0] strb);
        logic [15:0] r;
        r = old;
        if (strb[0]) begin
            r[7:0] = nw[7:0];
        end
        if (strb[1]) begin
            r[15:8] = nw[15:8];
        end
        return r;
    endfunction

    always_comb begin
        s_d          = s_q;
        wr_flag      = 1'b0;
        wr_set       = 1'b0;
        wmerged      = 16'h0000;
        s_d.awready  = 1'b0;
        s_d.wready   = 1'b0;
        s_d.arready  = 1'b0;
        // Capture address and data independently
        if (s_axi_awvalid && s_q.awready) begin
            s_d.aw_held = 1'b1;
            s_d.awaddr  = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_q.wready) begin
            s_d.w_held = 1'b1;
            s_d.wdata  = s_axi_wdata[15:0];
            s_d.wstrb  = s_axi_wstrb[1:0];
        end
        if (!s_d.aw_held && !s_q.bvalid && !(s_axi_awvalid && s_q.awready)) begin
            s_d.awready = s_axi_awvalid;
        end
        if (!s_d.w_held && !s_q.bvalid && !(s_axi_wvalid && s_q.wready)) begin
            s_d.wready = s_axi_wvalid;
        end
        if (s_q.aw_held && s_q.w_held && !s_q.bvalid) begin
            s_d.aw_held = 1'b0;
            s_d.w_held  = 1'b0;
            s_d.bvalid  = 1'b1;
            s_d.bresp   = IFB_RESP_OKAY;
            unique case (s_q.awaddr[3:2])
                IFB_OFS_FLAG[3:2]: begin
                    wr_flag = 1'b1;
                    wmerged = ifb_merge(fl.flags, s_q.wdata, s_q.wstrb);
                end
                IFB_OFS_SET[3:2]: begin
                    wr_set  = 1'b1;
                    wmerged = ifb_merge(16'h0000, s_q.wdata, s_q.wstrb);
                end
                IFB_OFS_MASK[3:2]: begin
                    s_d.mask = ifb_merge(s_q.mask, s_q.wdata, s_q.wstrb) & IFB_IMPL_MASK;
                end
                IFB_OFS_PEND[3:2]: begin
                    s_d.bresp = IFB_RESP_SLVERR;
                end
            endcase
        end
        if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end
        // Read channel
        if (s_axi_arvalid && s_q.arready) begin
            s_d.rvalid = 1'b1;
            s_d.rresp  = IFB_RESP_OKAY;
            unique case (s_axi_araddr[3:2])
                IFB_OFS_FLAG[3:2]: s_d.rdata = {16'h0000, fl.flags};
                IFB_OFS_SET[3:2]:  s_d.rdata = 32'h0000_0000;
                IFB_OFS_MASK[3:2]: s_d.rdata = {16'h0000, s_q.mask};
                IFB_OFS_PEND[3:2]: s_d.rdata = {16'h0000, fl.flags & s_q.mask};
            endcase
        end else if (!s_q.rvalid && !s_q.arready) begin
            s_d.arready = s_axi_arvalid;
        end
        if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
        end
        s_d.irq = |(fl.flags & s_q.mask);
    end

    assign fl.wr_flag = wr_flag;
    assign fl.wr_set  = wr_set;
    assign fl.wdata   = wmerged;

    ifb_flag_bank u_bank (
        .clk    (clk),
        .arst_n (arst_n),
        .req    (req),
        .fl     (fl.bank)
    );

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q      <= '0;
            s_q.mask <= IFB_MASK_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign s_axi_awready = s_q.awready;
    assign s_axi_wready  = s_q.wready;
    assign s_axi_bvalid  = s_q.bvalid;
    assign s_axi_bresp   = s_q.bresp;
    assign s_axi_arready = s_q.arready;
    assign s_axi_rvalid  = s_q.rvalid;
    assign s_axi_rdata   = s_q.rdata;
    assign s_axi_rresp   = s_q.rresp;
    assign irq           = s_q.irq;

    sequence ifb_read_req;
        s_axi_arvalid && s_axi_arready && s_axi_araddr[3:2] == IFB_OFS_FLAG[3:2];
    endsequence

    read_upper_a: assert property (@(posedge clk) disable iff (!arst_n)
        ifb_read_req |=> s_axi_rvalid && s_axi_rdata[31:14] == 18'h00000
                         && !s_axi_rdata[4])
        else $error("unimplemented bits read nonzero");
    read_flags_a: assert property (@(posedge clk) disable iff (!arst_n)
        ifb_read_req |=> s_axi_rdata[15:0] == $past(fl.flags))
        else $error("flag read mismatch");
    tx_req_read_a: assert property (@(posedge clk) disable iff (!arst_n)
        serial_tx_req ##1 (!wr_flag) |-> fl.flags[IFB_BIT_STX])
        else $error("transmit flag not set");
    ext0_set_a: assert property (@(posedge clk) disable iff (!arst_n)
        (ext_int0_req && !wr_flag) |=> fl.flags[IFB_BIT_EXT0])
        else $error("external flag not set");
    irq_level_a: assert property (@(posedge clk) disable iff (!arst_n)
        ##1 irq == $past(|(fl.flags & s_q.mask)))
        else $error("irq does not follow masked flags");
    resp_bound_a: assert property (@(posedge clk) disable iff (!arst_n)
        (s_q.aw_held && s_q.w_held && !s_axi_bvalid) |=> s_axi_bvalid)
        else $error("write response late");
endmodule : ifb_top

// ==== tb/ifb_periph_model.sv ====
// Model of the peripherals that raise requests into the flag word.
// Assumes the bench names the sources to fire, one clock cycle at a time.
`timescale 1ns/100ps
module ifb_periph_model (
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic [15:0] fire,
    output logic      [15:0] req
);
    // Each named source raises its request one cycle after fire and holds it high as long as fire stays high
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            req <= 16'h0000;
        end else begin
            req <= fire;
        end
    end
endmodule // ifb_periph_model

// ==== tb/tb.sv ====
// Self-checking bench for the first interrupt flag word over AXI4-Lite.
// Assumes the peripheral model and the design files are compiled first.
`timescale 1ns/100ps
module tb;
    import ifb_pkg::*;
    logic clk, arst_n, awv, wv, bre, arv, rre, awr, wr, bv, arr, rv, irq;
    logic [3:0]  awa, ara, wst;
    logic [31:0] wd, rd;
    logic [1:0]  br, rr;
    logic [15:0] fire, req;
    int n_errors = 0;
    int cmp_count = 0;
    int srcs[13] = '{13, 12, 11, 10, 9, 8, 7, 6, 5, 3, 2, 1, 0};
    ifb_periph_model pm (.clk(clk), .arst_n(arst_n), .fire(fire), .req(req));
    ifb_top dut (.clk(clk), .arst_n(arst_n), .converter_done_req(req[13]),
        .serial_tx_req(req[12]), .serial_rx_req(req[11]), .spi_event_req(req[10]),
        .spi_fault_req(req[9]), .timer3_req(req[8]), .timer2_req(req[7]),
        .compare2_req(req[6]), .capture2_req(req[5]), .timer1_req(req[3]),
        .compare1_req(req[2]), .capture1_req(req[1]), .ext_int0_req(req[0]),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
        .s_axi_wstrb(wst), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br),
        .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv),
        .s_axi_rready(rre), .irq(irq));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
        end
    endtask
    task automatic axi_wr(input logic [3:0] a, input logic [15:0] d, output logic [1:0] r,
                          input logic [3:0] s = 4'hF);
        logic aw, w;
        aw = 1'b0;
        w = 1'b0;
        @(posedge clk);
        awa <= a; wd <= {16'h0000, d}; wst <= s; awv <= 1'b1; wv <= 1'b1; bre <= 1'b1;
        while (!(aw && w)) begin
            @(posedge clk);
            if (!aw && awr === 1'b1) begin
                aw = 1'b1;
                awv <= 1'b0;
            end
            if (!w && wr === 1'b1) begin
                w = 1'b1;
                wv <= 1'b0;
            end
        end
        do @(posedge clk); while (bv !== 1'b1);
        r = br;
        bre <= 1'b0;
    endtask
    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        ara <= a; arv <= 1'b1; rre <= 1'b1;
        do @(posedge clk); while (arr !== 1'b1);
        arv <= 1'b0;
        while (rv !== 1'b1) @(posedge clk);
        d = rd;
        rre <= 1'b0;
    endtask
    task automatic pulse(input logic [15:0] m);
        @(posedge clk);
        fire <= m;
        @(posedge clk);
        fire <= 16'h0000;
        repeat (4) @(posedge clk);
    endtask
    task automatic t_reset();
        logic [31:0] d;
        axi_rd(IFB_OFS_FLAG, d);
        chk("flag word after reset", d, 32'h0000_0000);
        axi_rd(IFB_OFS_MASK, d);
        chk("mask after reset", d, 32'h0000_0000);
        chk("irq after reset", {31'h0, irq}, 32'h0000_0000);
    endtask
    task automatic t_sources();
        logic [31:0] d;
        logic [1:0]  r;
        foreach (srcs[i]) begin
            pulse(16'h0001 << srcs[i]);
            axi_rd(IFB_OFS_FLAG, d);
            chk("single source flag", d, 32'h1 << srcs[i]);
            axi_wr(IFB_OFS_FLAG, 16'h0000, r);
            axi_rd(IFB_OFS_FLAG, d);
            chk("flag cleared by write", d, 32'h0000_0000);
        end
    endtask
    task automatic t_unimpl();
        logic [31:0] d;
        logic [1:0]  r;
        axi_wr(IFB_OFS_FLAG, 16'hFFFF, r);
        chk("write response", {30'h0, r}, 32'h0000_0000);
        axi_rd(IFB_OFS_FLAG, d);
        chk("forced flags", d, 32'h0000_3FEF);
        axi_wr(4'hC, 16'h0000, r);
        chk("read-only write response", {30'h0, r}, 32'h0000_0002);
        axi_rd(IFB_OFS_FLAG, d);
        chk("flags kept after refused write", d, 32'h0000_3FEF);
        axi_wr(IFB_OFS_FLAG, 16'h0000, r);
        axi_rd(IFB_OFS_FLAG, d);
        chk("flags cleared", d, 32'h0000_0000);
    endtask
    task automatic t_irq();
        logic [31:0] d;
        logic [1:0]  r;
        axi_wr(IFB_OFS_MASK, 16'h2000, r);
        pulse(16'h1000);
        chk("irq masked source", {31'h0, irq}, 32'h0000_0000);
        pulse(16'h2000);
        chk("irq unmasked source", {31'h0, irq}, 32'h0000_0001);
        axi_rd(IFB_OFS_PEND, d);
        chk("pending word", d, 32'h0000_2000);
        axi_wr(IFB_OFS_FLAG, 16'h0000, r);
        repeat (3) @(posedge clk);
        chk("irq after clear", {31'h0, irq}, 32'h0000_0000);
        axi_wr(IFB_OFS_SET, 16'h0001, r);
        axi_rd(IFB_OFS_FLAG, d);
        chk("flag forced by set", d, 32'h0000_0001);
    endtask
    task automatic t_regs();
        logic [31:0] d;
        logic [1:0]  r;
        axi_wr(IFB_OFS_MASK, 16'h2001, r);
        axi_rd(IFB_OFS_MASK, d);
        chk("mask readback", d, 32'h0000_2001);
        chk("read response", {30'h0, rr}, 32'h0000_0000);
        axi_wr(IFB_OFS_MASK, 16'h0000, r);
        axi_rd(IFB_OFS_SET, d);
        chk("set register reads zero", d, 32'h0000_0000);
        axi_wr(IFB_OFS_FLAG, 16'hFFFF, r, 4'h2);
        axi_rd(IFB_OFS_FLAG, d);
        chk("upper lane write", d, 32'h0000_3F01);
        axi_wr(IFB_OFS_FLAG, 16'h0000, r, 4'h1);
        axi_rd(IFB_OFS_FLAG, d);
        chk("lower lane write", d, 32'h0000_3F00);
        axi_wr(IFB_OFS_FLAG, 16'h0000, r);
    endtask
    initial begin
        arst_n = 1'b0; awv = 1'b0; wv = 1'b0; bre = 1'b0; arv = 1'b0; rre = 1'b0;
        awa = 4'h0; ara = 4'h0; wst = 4'h0; wd = 32'h0; fire = 16'h0000;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        t_reset();
        t_sources();
        t_unimpl();
        t_irq();
        t_regs();
        tally_and_finish();
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        tally_and_finish();
    end
endmodule // tb
